// file: rtl/pgen_cfg.svh
// register offsets, field positions, reset values and sizes of the pulse generator
`ifndef PGEN_CFG_SVH
`define PGEN_CFG_SVH
`define PGEN_ADDR_W 16
`define PGEN_NUM_CH 6
// register indexes; the byte address is four times the index
`define PGEN_IDX_MASK 16'h07b0
`define PGEN_IDX_STATUS 16'h07b1
`define PGEN_IDX_CTRL 16'h0780
`define PGEN_IDX_MODE 16'h0781
`define PGEN_IDX_PULSE_NUM 16'h0782
`define PGEN_IDX_SHADOW 16'h0783
`define PGEN_IDX_SEQ_STATE 16'h0784
`define PGEN_IDX_CHCFG_BASE 16'h0790
`define PGEN_IDX_PHASE_BASE 16'h07a0
// control register fields
`define PGEN_CTRL_EN_LSB 0
`define PGEN_CTRL_DMA_START 8
`define PGEN_CTRL_DMA_STOP 9
// status register fields
`define PGEN_ST_COUNT_DONE 0
`define PGEN_ST_FIFO_DRAINED 1
`define PGEN_ST_FRAME_LSB 2
// descriptor fields
`define PGEN_DESC_CARRIER 15
`define PGEN_DESC_SOURCE 14
`define PGEN_DESC_FRAMES_MSB 13
// reset values
`define PGEN_RST_MASK 8'h00
`define PGEN_RST_STATUS 8'h00
`define PGEN_RST_EN 6'h00
`define PGEN_RST_CYCLE 16'h0000
`define PGEN_RST_CMP 16'h0000
`define PGEN_RST_PHASE 16'h0000
`define PGEN_RST_PULSE_NUM 16'h0000
`endif

// file: rtl/pgen_pkg.sv
// types shared by the pulse generator modules
package pgen_pkg;
   typedef enum logic [2:0] {
      PGEN_MODE_NORMAL = 3'b000,
      PGEN_MODE_COUNT = 3'b001,
      PGEN_MODE_IR = 3'b010,
      PGEN_MODE_IR_FIFO = 3'b011,
      PGEN_MODE_IR_DMA = 3'b100
   } pgen_mode_t;

   typedef enum logic [1:0] {
      PGEN_SEQ_IDLE = 2'b00,
      PGEN_SEQ_FETCH = 2'b01,
      PGEN_SEQ_PLAY = 2'b10
   } pgen_seq_state_t;

   // one waveform descriptor as the dma hands it over
   typedef struct packed {
      logic carrier;
      logic alternate;
      logic [13:0] frames;
   } pgen_desc_t;

   // frame setting of one channel
   typedef struct packed {
      logic [15:0] cycle;
      logic [15:0] cmp;
   } pgen_frame_cfg_t;
endpackage : pgen_pkg

// file: rtl/pgen_chan.sv
// one frame generator: phase delay, then frames of cmp high and cycle-cmp low
`timescale 1ns/1ps
`default_nettype none
module pgen_chan
   import pgen_pkg::*;
(
   input wire logic pclk, // generator clock
   input wire logic presetn, // async reset, active low
   input wire logic run, // channel running
   input wire logic carrier, // high pulse allowed in this frame
   input wire pgen_pkg::pgen_frame_cfg_t cfg, // cycle and compare of the frame
   input wire logic [15:0] phase, // start delay in clocks
   output logic wave, // waveform, combinational
   output logic frame_end // last clock of a frame, combinational
);
   logic started;
   logic delaying;
   logic [15:0] delay_cnt;
   logic [15:0] cnt;
   logic [15:0] last;
   logic active;

   // a zero cycle is treated as one clock so the counter never runs away
   assign last = (cfg.cycle == 16'h0000) ? 16'h0000 : cfg.cycle - 16'h0001;
   assign active = run && started && !delaying;
   assign frame_end = active && (cnt >= last); // [R6]
   assign wave = active && carrier && (cnt < cfg.cmp); // [R22] [R13]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         started <= 1'b0;
         delaying <= 1'b0;
         delay_cnt <= 16'h0000;
         cnt <= 16'h0000;
      end else if (!run) begin
         started <= 1'b0;
         delaying <= 1'b0;
         cnt <= 16'h0000;
      end else if (!started) begin
         started <= 1'b1;
         delay_cnt <= phase; // [R11]
         delaying <= (phase != 16'h0000); // [R11]
         cnt <= 16'h0000;
      end else if (delaying) begin
         delay_cnt <= delay_cnt - 16'h0001;
         if (delay_cnt == 16'h0001) begin
            delaying <= 1'b0;
         end
      end else if (cnt >= last) begin
         cnt <= 16'h0000;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule : pgen_chan
`default_nettype wire

// file: rtl/pgen_slot.sv
// one-entry descriptor holding slot so the next waveform is ready at a frame boundary
`timescale 1ns/1ps
`default_nettype none
module pgen_slot
   import pgen_pkg::*;
(
   input wire logic pclk, // generator clock
   input wire logic presetn, // async reset, active low
   input wire logic accept, // sequencer wants descriptors
   input wire logic flush, // drop held descriptor
   input wire logic in_valid, // dma offers a descriptor
   input wire pgen_pkg::pgen_desc_t in_desc, // offered descriptor
   input wire logic in_last, // offered descriptor ends the buffer
   output logic in_ready, // slot can take a descriptor, registered
   output logic out_valid, // descriptor held
   output pgen_pkg::pgen_desc_t out_desc, // held descriptor
   output logic out_last, // held descriptor ends the buffer
   input wire logic take // sequencer consumes the held descriptor
);
   logic next_full;

   always_comb begin
      next_full = out_valid;
      if (flush) begin
         next_full = 1'b0;
      end else if (in_valid && in_ready) begin
         next_full = 1'b1;
      end else if (take) begin
         next_full = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         in_ready <= 1'b0;
         out_desc <= '0;
         out_last <= 1'b0;
      end else begin
         out_valid <= next_full;
         // ready only rises once the slot has been emptied
         in_ready <= accept && !flush && !next_full;
         if (in_valid && in_ready && !flush) begin
            out_desc <= in_desc; // [R12]
            out_last <= in_last;
         end
      end
   end
endmodule : pgen_slot
`default_nettype wire

// file: rtl/pgen_irq_seq.sv
// six-channel pulse generator with event flags and channel-0 dma waveform sequencer
// Overview of operation
// [R1] A status bit sets on its event whatever the mask holds.
// [R2] Writing 1 to a status bit clears it; writing 0 leaves it.
// [R3] Interrupt rises only when status and all mask layers are set.
// [R4] Mask register at index 0x7b0, status at 0x7b1, bit n gates bit n.
// [R5] Bit 0 count done, bit 1 fifo drained, bits 2-7 channel 0-5 frame ends.
// [R6] Every channel flags the end of each frame in every mode.
// [R7] Channel 0 flags count done at the counted frame, counting and IR modes.
// [R8] In dma mode channel 0 flags fifo drained after all descriptors played.
// [R9] Software enables local mask, system mask bit 14 and global enable.
// [R10] Software clears stale status before setting its mask bit.
// [R11] Each channel waits its phase delay before output; zero means none.
// [R12] Descriptors play in order, back to back, without gaps; here an empty slot or a zero-frame descriptor at a boundary costs a gap.
// [R13] Descriptor bit 15 on gives high pulses, off gives all-zero frames.
// [R14] Descriptor bit 14 picks the primary or alternate frame setting.
// [R15] Exactly the descriptor's frame count is played before the next one.
// [R16] Channel 0 holds a second cycle and compare pair for alternate frames.
// [R17] Software prepares the buffer and dma address before starting.
// [R18] After the last descriptor the sequencer stops on its own.
// [R19] A manual stop halts dma sequencing at once.
// [R20] Once started the sequence runs without processor help.
// [R21] Dma mode exists on channel 0 only, on both its outputs.
// [R22] A frame is high for compare clocks, then low for the rest.
// [R23] Each channel drives an inverted copy of its waveform.
// [R24] Descriptor bits 13 to 0 give the unsigned frame count.
`timescale 1ns/1ps
`default_nettype none
`include "pgen_cfg.svh"
module pgen_irq_seq (
   input wire logic pclk, // generator clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [`PGEN_ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic desc_valid, // dma offers a descriptor
   input wire pgen_pkg::pgen_desc_t desc_data, // descriptor word
   input wire logic desc_last, // descriptor is the last of the buffer
   output logic desc_ready, // descriptor taken when high with valid
   output logic [5:0] pulse_out, // channel waveforms
   output logic [5:0] pulse_out_n, // inverted waveforms, ch0_inverted_output at bit 0
   output logic pulse_irq // event interrupt request
);
   import pgen_pkg::*;

   logic [7:0] pulse_event_mask;
   logic [7:0] pulse_event_status;
   logic [5:0] chan_enable;
   pgen_mode_t mode;
   logic [15:0] pulse_num;
   pgen_frame_cfg_t shadow_cfg;
   pgen_frame_cfg_t chan_cfg [0:5];
   logic [15:0] chan_phase [0:5];

   logic [`PGEN_ADDR_W-1:0] idx;
   logic wr_access;
   logic rd_access;
   logic hit;
   logic [31:0] rd_value;
   logic [7:0] status_clr;
   logic dma_start_req;
   logic dma_stop_req;

   pgen_seq_state_t seq_state;
   pgen_desc_t cur_desc;
   logic cur_last;
   logic [13:0] frames_left;
   logic [15:0] pulses_seen;

   logic [5:0] run;
   logic [5:0] wave;
   logic [5:0] frame_end;
   logic ch0_carrier;
   pgen_frame_cfg_t ch0_cfg;
   logic dma_mode;
   logic count_mode;
   logic count_hit;
   logic count_stop;
   logic fifo_drained_flag;
   logic ch0_count_done_flag;
   logic [7:0] event_set;

   logic slot_valid;
   pgen_desc_t slot_desc;
   logic slot_last;
   logic slot_take;
   logic slot_flush;

   // ---------------- apb slave ----------------
   // registers sit one per word; the printed offsets are word indexes
   assign idx = {2'b00, paddr[`PGEN_ADDR_W-1:2]};
   assign wr_access = psel && penable && pwrite && !pready;
   assign rd_access = psel && penable && !pwrite && !pready;

   always_comb begin
      hit = 1'b1;
      rd_value = 32'h0000_0000;
      if (idx == `PGEN_IDX_MASK) begin
         rd_value = {24'h000000, pulse_event_mask}; // [R4]
      end else if (idx == `PGEN_IDX_STATUS) begin
         rd_value = {24'h000000, pulse_event_status}; // [R4]
      end else if (idx == `PGEN_IDX_CTRL) begin
         rd_value = {26'h0000000, chan_enable};
      end else if (idx == `PGEN_IDX_MODE) begin
         rd_value = {29'h00000000, mode};
      end else if (idx == `PGEN_IDX_PULSE_NUM) begin
         rd_value = {16'h0000, pulse_num};
      end else if (idx == `PGEN_IDX_SHADOW) begin
         rd_value = shadow_cfg;
      end else if (idx == `PGEN_IDX_SEQ_STATE) begin
         rd_value = {cur_last, 13'h0000, seq_state, frames_left, slot_valid, 1'b0};
      end else if (idx >= `PGEN_IDX_CHCFG_BASE && idx < `PGEN_IDX_CHCFG_BASE + 16'h0006) begin
         rd_value = chan_cfg[3'(idx - `PGEN_IDX_CHCFG_BASE)];
      end else if (idx >= `PGEN_IDX_PHASE_BASE && idx < `PGEN_IDX_PHASE_BASE + 16'h0006) begin
         rd_value = {16'h0000, chan_phase[3'(idx - `PGEN_IDX_PHASE_BASE)]};
      end else begin
         hit = 1'b0;
      end
   end

   // the answer comes one cycle into the access phase, from registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !hit;
         prdata <= rd_access ? rd_value : 32'h0000_0000;
      end
   end

   assign status_clr = (wr_access && idx == `PGEN_IDX_STATUS) ? pwdata[7:0] : 8'h00;
   assign dma_start_req = wr_access && idx == `PGEN_IDX_CTRL && pwdata[`PGEN_CTRL_DMA_START];
   assign dma_stop_req = wr_access && idx == `PGEN_IDX_CTRL && pwdata[`PGEN_CTRL_DMA_STOP];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_event_mask <= `PGEN_RST_MASK;
         mode <= PGEN_MODE_NORMAL;
         pulse_num <= `PGEN_RST_PULSE_NUM;
         shadow_cfg <= {`PGEN_RST_CYCLE, `PGEN_RST_CMP};
      end else if (wr_access) begin
         if (idx == `PGEN_IDX_MASK) begin
            pulse_event_mask <= pwdata[7:0];
         end else if (idx == `PGEN_IDX_MODE) begin
            mode <= pgen_mode_t'(pwdata[2:0]);
         end else if (idx == `PGEN_IDX_PULSE_NUM) begin
            pulse_num <= pwdata[15:0];
         end else if (idx == `PGEN_IDX_SHADOW) begin
            shadow_cfg <= pwdata; // [R16]
         end
      end
   end

   // channel enables; counting mode drops channel 0 on its own when done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_enable <= `PGEN_RST_EN;
      end else if (wr_access && idx == `PGEN_IDX_CTRL) begin
         chan_enable <= pwdata[`PGEN_CTRL_EN_LSB +: 6];
      end else if (count_stop) begin
         chan_enable[0] <= 1'b0;
      end
   end

   generate
      for (genvar n = 0; n < `PGEN_NUM_CH; n++) begin : g_cfg
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               chan_cfg[n] <= {`PGEN_RST_CYCLE, `PGEN_RST_CMP};
               chan_phase[n] <= `PGEN_RST_PHASE;
            end else if (wr_access) begin
               if (idx == `PGEN_IDX_CHCFG_BASE + 16'(n)) begin
                  chan_cfg[n] <= pwdata;
               end
               if (idx == `PGEN_IDX_PHASE_BASE + 16'(n)) begin
                  chan_phase[n] <= pwdata[15:0];
               end
            end
         end
      end
   endgenerate

   // ---------------- channel 0 mode logic ----------------
   assign dma_mode = (mode == PGEN_MODE_IR_DMA); // [R21]
   assign count_mode = (mode == PGEN_MODE_COUNT) || (mode == PGEN_MODE_IR);
   assign count_hit = count_mode && frame_end[0] && (pulses_seen + 16'h0001 == pulse_num);
   assign ch0_count_done_flag = count_hit; // [R7]
   assign count_stop = count_hit && (mode == PGEN_MODE_COUNT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulses_seen <= 16'h0000;
      end else if (!run[0] || !count_mode || count_hit) begin
         pulses_seen <= 16'h0000;
      end else if (frame_end[0]) begin
         pulses_seen <= pulses_seen + 16'h0001;
      end
   end

   // in dma mode the frame setting and carrier follow the playing descriptor
   assign ch0_carrier = dma_mode ? cur_desc.carrier : 1'b1; // [R13]
   assign ch0_cfg = (dma_mode && cur_desc.alternate) ? shadow_cfg : chan_cfg[0]; // [R14] [R16]
   assign run[0] = dma_mode ? (seq_state == PGEN_SEQ_PLAY) : chan_enable[0];
   assign run[5:1] = chan_enable[5:1];

   // ---------------- descriptor sequencer ----------------
   // the slot is refilled while a waveform plays so the next one can start on the
   // very next clock; an empty slot at a boundary is an underrun and costs a gap
   always_comb begin
      slot_take = 1'b0;
      if (dma_mode && !dma_stop_req && slot_valid) begin
         if (seq_state == PGEN_SEQ_FETCH) begin
            slot_take = 1'b1;
         end else if (seq_state == PGEN_SEQ_PLAY && frame_end[0] && frames_left == 14'h0001 && !cur_last) begin
            slot_take = 1'b1; // [R12]
         end
      end
   end

   assign slot_flush = dma_stop_req || !dma_mode || seq_state == PGEN_SEQ_IDLE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_state <= PGEN_SEQ_IDLE;
         cur_desc <= '0;
         cur_last <= 1'b0;
         frames_left <= 14'h0000;
         fifo_drained_flag <= 1'b0;
      end else begin
         fifo_drained_flag <= 1'b0;
         if (dma_stop_req || !dma_mode) begin
            seq_state <= PGEN_SEQ_IDLE; // [R19]
         end else begin
            case (seq_state)
               PGEN_SEQ_IDLE: begin
                  if (dma_start_req) begin
                     seq_state <= PGEN_SEQ_FETCH;
                  end
               end
               PGEN_SEQ_FETCH: begin
                  if (slot_valid) begin
                     cur_desc <= slot_desc;
                     cur_last <= slot_last;
                     frames_left <= slot_desc.frames; // [R24]
                     if (slot_desc.frames != 14'h0000) begin
                        seq_state <= PGEN_SEQ_PLAY;
                     end else if (slot_last) begin
                        seq_state <= PGEN_SEQ_IDLE;
                        fifo_drained_flag <= 1'b1;
                     end
                  end
               end
               PGEN_SEQ_PLAY: begin
                  if (frame_end[0]) begin
                     if (frames_left != 14'h0001) begin
                        frames_left <= frames_left - 14'h0001; // [R15]
                     end else if (cur_last) begin
                        seq_state <= PGEN_SEQ_IDLE; // [R18] [R20]
                        fifo_drained_flag <= 1'b1; // [R8]
                     end else if (slot_valid && slot_desc.frames != 14'h0000) begin
                        cur_desc <= slot_desc; // [R12]
                        cur_last <= slot_last;
                        frames_left <= slot_desc.frames;
                     end else begin
                        // underruns and non-last zero-frame descriptors go back to fetch; a zero-frame last one ends here
                        seq_state <= PGEN_SEQ_FETCH;
                        if (slot_valid) begin
                           cur_last <= slot_last;
                           if (slot_last) begin
                              seq_state <= PGEN_SEQ_IDLE;
                              fifo_drained_flag <= 1'b1;
                           end
                        end
                     end
                  end
               end
               default: begin
                  seq_state <= PGEN_SEQ_IDLE;
               end
            endcase
         end
      end
   end

   pgen_slot u_slot (
      .pclk(pclk),
      .presetn(presetn),
      .accept(dma_mode && seq_state != PGEN_SEQ_IDLE),
      .flush(slot_flush),
      .in_valid(desc_valid),
      .in_desc(desc_data),
      .in_last(desc_last),
      .in_ready(desc_ready),
      .out_valid(slot_valid),
      .out_desc(slot_desc),
      .out_last(slot_last),
      .take(slot_take)
   );

   // ---------------- frame generators ----------------
   generate
      for (genvar n = 0; n < `PGEN_NUM_CH; n++) begin : g_chan
         pgen_chan u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .run(run[n]),
            .carrier((n == 0) ? ch0_carrier : 1'b1),
            .cfg((n == 0) ? ch0_cfg : chan_cfg[n]),
            .phase(chan_phase[n]),
            .wave(wave[n]),
            .frame_end(frame_end[n])
         );
      end
   endgenerate

   // both outputs come from the same edge, so the pair never overlaps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_out <= 6'h00;
         pulse_out_n <= 6'h3f;
      end else begin
         pulse_out <= wave; // [R21]
         pulse_out_n <= ~wave; // [R23]
      end
   end

   // ---------------- event flags ----------------
   assign event_set = {frame_end, fifo_drained_flag, ch0_count_done_flag}; // [R5]

   // a set in the clearing cycle wins, so no event is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_event_status <= `PGEN_RST_STATUS;
      end else begin
         pulse_event_status <= (pulse_event_status & ~status_clr) | event_set; // [R1] [R2]
      end
   end

   // only the local layer lives here; system mask and global enable sit upstream
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_irq <= 1'b0;
      end else begin
         pulse_irq <= |(pulse_event_status & pulse_event_mask); // [R3] [R9]
      end
   end
endmodule : pgen_irq_seq
`default_nettype wire

// file: tb/pgen_irq_seq_monitor.sv
// concurrent checks on the pulse generator ports
`timescale 1ns/1ps
`default_nettype none
`include "pgen_cfg.svh"
module pgen_irq_seq_monitor (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb write
   input wire logic [`PGEN_ADDR_W-1:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic desc_valid, // descriptor offered
   input wire pgen_pkg::pgen_desc_t desc_data, // descriptor word
   input wire logic desc_last, // last descriptor
   input wire logic desc_ready, // descriptor taken
   input wire logic [5:0] pulse_out, // waveforms
   input wire logic [5:0] pulse_out_n, // inverted waveforms
   input wire logic pulse_irq // interrupt request
);
   import pgen_pkg::*;
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_wr(logic [15:0] a);
      pready && psel && pwrite && paddr == a;
   endsequence
   a_inv_copy: assert property (pulse_out_n == ~pulse_out)
      else $error("inverted output differs");
   a_one_wait: assert property (s_wait |=> pready)
      else $error("apb answer late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without ready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_take_drop: assert property (desc_valid && desc_ready |=> !desc_ready)
      else $error("slot accepted twice");
   a_mask_off: assert property (s_wr(`PGEN_IDX_MASK << 2) ##0 pwdata[7:0] == 8'h00 |=> !pulse_irq)
      else $error("interrupt with mask cleared");
   a_stop_idle: assert property (s_wr(`PGEN_IDX_CTRL << 2) ##0 pwdata[9] |=> !desc_ready)
      else $error("descriptors accepted after stop");
endmodule : pgen_irq_seq_monitor
bind pgen_irq_seq pgen_irq_seq_monitor pgen_irq_seq_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .desc_valid, .desc_data, .desc_last, .desc_ready,
   .pulse_out, .pulse_out_n, .pulse_irq);
`default_nettype wire

// file: tb/pgen_dma_src.sv
// dma side model: offers queued descriptors, holding each until taken
`timescale 1ns/1ps
`default_nettype none
module pgen_dma_src (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic slow, // hold back each offer
   input wire logic desc_ready, // design takes a word
   output logic desc_valid, // word offered
   output pgen_pkg::pgen_desc_t desc_data, // offered word
   output logic desc_last // word ends the buffer
);
   import pgen_pkg::*;
   pgen_desc_t q_d[$];
   logic q_l[$];
   int gap;
   // buffer is filled before the start command
   task automatic push(input pgen_desc_t dd, input logic l);
      q_d.push_back(dd);
      q_l.push_back(l);
   endtask : push
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {desc_valid, desc_data, desc_last} <= '0;
         gap <= 0;
      end else if (!desc_valid || desc_ready) begin
         if (desc_valid) begin
            void'(q_d.pop_front());
            void'(q_l.pop_front());
         end
         if (q_d.size() > 0 && (!slow || gap >= 3)) begin
            {desc_valid, desc_data, desc_last} <= {1'b1, q_d[0], q_l[0]};
            gap <= 0;
         end else begin
            // while nothing is offered the word on the bus is inverted every clock
            {desc_valid, desc_data, desc_last} <= {1'b0, ~desc_data, ~desc_last};
            gap <= gap + 1;
         end
      end
   end
endmodule : pgen_dma_src
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "pgen_cfg.svh"
module tb_top;
   import pgen_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, e;
   logic [15:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, v, r;
   logic pready, pslverr, desc_valid, desc_last, desc_ready, pulse_irq;
   pgen_desc_t desc_data, d;
   logic [5:0] pulse_out, pulse_out_n;
   int error_cnt = 0, checks_done = 0, cyc = 0, n, m;
   logic exp_q[$];
   localparam logic [15:0] ad_mask = `PGEN_IDX_MASK << 2, ad_st = `PGEN_IDX_STATUS << 2;
   localparam logic [15:0] ad_ctrl = `PGEN_IDX_CTRL << 2, ad_mode = `PGEN_IDX_MODE << 2;
   localparam logic [15:0] ad_np = `PGEN_IDX_PULSE_NUM << 2, ad_sh = `PGEN_IDX_SHADOW << 2;
   localparam logic [15:0] ad_cfg = `PGEN_IDX_CHCFG_BASE << 2, ad_ph = `PGEN_IDX_PHASE_BASE << 2;
   always #20 pclk = ~pclk;
   pgen_irq_seq pgen_irq_seq_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .desc_valid, .desc_data, .desc_last, .desc_ready, .pulse_out, .pulse_out_n, .pulse_irq);
   pgen_dma_src pgen_dma_src_inst (.pclk, .presetn, .slow, .desc_ready, .desc_valid, .desc_data, .desc_last);
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      v = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      void'($urandom(32'h0eec6ec5));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ad_mask, 0);
      chk(v, 0);
      apb(0, ad_st, 0);
      chk(v, 0);
      apb(0, 16'h1ffc, 0);
      chk(e, 1);
      r = $urandom;
      apb(1, ad_mask, r);
      apb(0, ad_mask, 0);
      chk(v, r & 32'hff);
      apb(1, ad_mask, 0);
      $display("test registers done");
      for (n = 0; n < 6; n++) apb(1, 16'(ad_cfg + 4 * n), {16'd3, 16'd1});
      apb(1, ad_ctrl, 32'h3f);
      repeat (20) @(negedge pclk);
      apb(1, ad_ctrl, 0);
      apb(0, ad_st, 0);
      chk(v, 32'hfc);
      chk(pulse_irq, 0);
      apb(1, ad_mask, 32'h04);
      repeat (2) @(negedge pclk);
      chk(pulse_irq, 1);
      apb(1, ad_st, 0);
      apb(0, ad_st, 0);
      chk(v, 32'hfc);
      apb(1, ad_st, 32'hff);
      apb(0, ad_st, 0);
      chk(v, 0);
      chk(pulse_irq, 0);
      apb(1, ad_mask, 0);
      $display("test flags done");
      apb(1, 16'(ad_ph + 4), 5);
      apb(1, ad_ctrl, 32'h06);
      for (n = 0; n < 50 && pulse_out[2] !== 1'b1; n++) @(negedge pclk);
      for (n = 0; n < 50 && pulse_out[1] !== 1'b1; n++) @(negedge pclk);
      chk(n, 5);
      apb(1, ad_ctrl, 0);
      $display("test phase done");
      apb(1, ad_mode, 1);
      apb(1, ad_np, 3);
      apb(1, ad_cfg, {16'd4, 16'd2});
      apb(1, ad_st, 32'hff);
      apb(1, ad_ctrl, 1);
      m = 0;
      repeat (60) begin
         @(negedge pclk);
         m += pulse_out[0];
      end
      chk(m, 6);
      apb(0, ad_st, 0);
      chk(v & 3, 1);
      apb(0, ad_ctrl, 0);
      chk(v, 0);
      apb(1, ad_mode, 2);
      apb(1, ad_ctrl, 1);
      repeat (40) @(negedge pclk);
      apb(0, ad_ctrl, 0);
      chk(v, 1);
      $display("test count done");
      apb(1, ad_mode, 4);
      apb(1, ad_cfg, {16'd4, 16'd1});
      apb(1, ad_sh, {16'd6, 16'd3});
      apb(1, ad_st, 32'hff);
      for (n = 0; n < 4; n++) begin
         d = 16'($urandom);
         d.frames = 14'($urandom_range(3, 1));
         if (n < 3) {d.carrier, d.alternate} = {n != 2, n == 1};
         pgen_dma_src_inst.push(d, n == 3);
         repeat (d.frames) for (m = 0; m < (d.alternate ? 6 : 4); m++)
            exp_q.push_back(d.carrier && m < (d.alternate ? 3 : 1));
      end
      apb(1, ad_ctrl, 32'h100);
      for (n = 0; n < 100 && pulse_out[0] !== 1'b1; n++) @(negedge pclk);
      foreach (exp_q[i]) begin
         chk(pulse_out[0], exp_q[i]);
         @(negedge pclk);
      end
      repeat (10) @(negedge pclk);
      chk(pulse_out[0], 0);
      apb(0, ad_st, 0);
      chk(v[1], 1);
      $display("test sequence done");
      apb(1, ad_st, 32'hff);
      slow <= 1'b1;
      pgen_dma_src_inst.push({1'b1, 1'b0, 14'd200}, 1'b1);
      apb(1, ad_ctrl, 32'h100);
      repeat (30) @(negedge pclk);
      apb(1, ad_ctrl, 32'h200);
      repeat (2) @(negedge pclk);
      chk({pulse_out[0], desc_ready}, 0);
      repeat (900) @(negedge pclk);
      apb(0, ad_st, 0);
      chk(v[1], 0);
      $display("test stop done");
      final_report();
   end
endmodule : tb_top
`default_nettype wire
